// >>> verilog/cwo_socket.sv
// One socket's copy of the card window offset registers.
// Addresses arrive as socket A local offsets.
`timescale 1ns/10ps
module cwo_socket
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   cwo_socket_if.sock rp,
   // Card side events and pins
   input wire logic card_removed_i,
   input wire logic detect_change_i,
   input wire logic status_clear_i,
   input wire logic detect_int_enable_i,
   input wire logic voltage_sense_one_i,
   input wire logic voltage_sense_two_i,
   // Decoded window state and detect outputs
   output logic [7:0] mem_hi_o [5],
   output logic [15:0] io_off0_o,
   output logic [15:0] io_off1_o,
   output logic soft_detect_interrupt_o,
   output logic ring_indicate_output_o
);
   logic [7:0] mem_hi_reg [5];
   logic [7:0] io_lo_reg [2];
   logic [7:0] io_hi_reg [2];
   logic [7:0] detect_reg;
   logic wake_reg;
   logic soft_reg;
   logic clear_all;
   logic [7:0] rd_next;
   logic [7:0] rdata_reg;

   assign clear_all = card_removed_i &
      detect_reg[cwo_pkg::CWO_CLEAR_BIT];

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < 5; i++)
            mem_hi_reg[i] <= cwo_pkg::CWO_RESET_VAL;
      end
      else if (clear_all)
      begin
         for (int i = 0; i < 5; i++)
            mem_hi_reg[i] <= cwo_pkg::CWO_RESET_VAL;
      end
      else if (rp.wr)
      begin
         for (int i = 0; i < 5; i++)
            if (rp.addr == cwo_pkg::CWO_MEMHI_A[i])
               mem_hi_reg[i] <= rp.wdata;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         io_lo_reg[0] <= cwo_pkg::CWO_RESET_VAL;
         io_lo_reg[1] <= cwo_pkg::CWO_RESET_VAL;
         io_hi_reg[0] <= cwo_pkg::CWO_RESET_VAL;
         io_hi_reg[1] <= cwo_pkg::CWO_RESET_VAL;
      end
      else if (clear_all)
      begin
         io_lo_reg[0] <= cwo_pkg::CWO_RESET_VAL;
         io_lo_reg[1] <= cwo_pkg::CWO_RESET_VAL;
         io_hi_reg[0] <= cwo_pkg::CWO_RESET_VAL;
         io_hi_reg[1] <= cwo_pkg::CWO_RESET_VAL;
      end
      else if (rp.wr)
      begin
         if (rp.addr == cwo_pkg::CWO_IOW0_LO_A)
            io_lo_reg[0] <= rp.wdata & cwo_pkg::CWO_IO_LO_MASK;
         if (rp.addr == cwo_pkg::CWO_IOW1_LO_A)
            io_lo_reg[1] <= rp.wdata & cwo_pkg::CWO_IO_LO_MASK;
         if (rp.addr == cwo_pkg::CWO_IOW0_HI_A)
            io_hi_reg[0] <= rp.wdata;
         if (rp.addr == cwo_pkg::CWO_IOW1_HI_A)
            io_hi_reg[1] <= rp.wdata;
      end
   end

   // Removal clears the detect register itself too, including bit 1
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         detect_reg <= cwo_pkg::CWO_RESET_VAL;
      else if (clear_all)
         detect_reg <= cwo_pkg::CWO_RESET_VAL;
      else if (rp.wr && rp.addr == cwo_pkg::CWO_DETECT_A)
         detect_reg <= rp.wdata & cwo_pkg::CWO_DETECT_WMASK;
   end

   // Write-only strobe, never stored
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         soft_reg <= 1'b0;
      else
         soft_reg <= rp.wr && rp.addr == cwo_pkg::CWO_DETECT_A &&
            rp.wdata[cwo_pkg::CWO_SOFT_BIT] && detect_int_enable_i;
   end

   // A new change wins over a clear in the same cycle
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         wake_reg <= 1'b0;
      else if (detect_change_i && detect_reg[cwo_pkg::CWO_WAKE_BIT])
         wake_reg <= 1'b1;
      else if (status_clear_i)
         wake_reg <= 1'b0;
   end

   always_comb
   begin
      rd_next = 8'h00;
      for (int i = 0; i < 5; i++)
         if (rp.addr == cwo_pkg::CWO_MEMHI_A[i])
            rd_next = mem_hi_reg[i];
      unique case (rp.addr)
         cwo_pkg::CWO_IOW0_LO_A: rd_next = io_lo_reg[0];
         cwo_pkg::CWO_IOW1_LO_A: rd_next = io_lo_reg[1];
         cwo_pkg::CWO_IOW0_HI_A: rd_next = io_hi_reg[0];
         cwo_pkg::CWO_IOW1_HI_A: rd_next = io_hi_reg[1];
         cwo_pkg::CWO_DETECT_A:
         begin
            rd_next = detect_reg;
            rd_next[cwo_pkg::CWO_VS2_BIT] = voltage_sense_two_i;
            rd_next[cwo_pkg::CWO_VS1_BIT] = voltage_sense_one_i;
         end
         default: ;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= rd_next;
   end

   assign rp.rdata = rdata_reg;
   assign mem_hi_o = mem_hi_reg;
   assign io_off0_o = {io_hi_reg[0], io_lo_reg[0]};
   assign io_off1_o = {io_hi_reg[1], io_lo_reg[1]};
   assign soft_detect_interrupt_o = soft_reg;
   assign ring_indicate_output_o = ~wake_reg;
endmodule // cwo_socket

// >>> verilog/cwo_pkg.sv
// Constants for the per-socket card window offset register bank.
// Assumes a byte-wide host register port with socket-local offsets.
// Notes on behaviour
// - A memory window whose write-protect bit 7 is set blocks card writes.
// - Bit 6 of a memory window high byte selects attribute (1) or common.
// - The six low bits of the high byte give card address bits 25 to 20.
// - Bit 0 of each I/O window low offset byte is read-only and reads 0.
// - The I/O low offset byte forms offset bits 7 to 0.
// - The I/O high offset byte, fully writable, forms offset bits 15 to 8.
// - Each socket has its own copies at 36h-39h (A) and 76h-79h (B).
// - The detect register reports both voltage-sense pins live in bits 7-6.
// - With bit 1 set, card removal returns the socket registers to default.
// - Writing 1 to bit 5 raises a soft detect interrupt if enabled; reads 0
// - With bit 4 set, a detect change holds ring indicate low till cleared.
// - Bits 3, 2 and 0 of the detect register read zero and ignore writes.
package cwo_pkg;
   localparam logic [7:0] CWO_DETECT_A = 8'h16;
   localparam logic [7:0] CWO_IOW0_LO_A = 8'h36;
   localparam logic [7:0] CWO_IOW0_HI_A = 8'h37;
   localparam logic [7:0] CWO_IOW1_LO_A = 8'h38;
   localparam logic [7:0] CWO_IOW1_HI_A = 8'h39;
   localparam logic [7:0] CWO_SOCKET_B_DELTA = 8'h40;
   localparam logic [11:0] CWO_ALIAS_BASE = 12'h800;
   localparam logic [7:0] CWO_MEMHI_A [5] = '{8'h15, 8'h1D, 8'h25, 8'h2D,
      8'h35};
   localparam int CWO_WP_BIT = 7;
   localparam int CWO_ATTR_BIT = 6;
   localparam int CWO_VS2_BIT = 7;
   localparam int CWO_VS1_BIT = 6;
   localparam int CWO_SOFT_BIT = 5;
   localparam int CWO_WAKE_BIT = 4;
   localparam int CWO_CLEAR_BIT = 1;
   localparam logic [7:0] CWO_IO_LO_MASK = 8'hFE;
   localparam logic [7:0] CWO_DETECT_WMASK = 8'h12;
   localparam logic [7:0] CWO_RESET_VAL = 8'h00;
   localparam int CWO_NUM_MEMWIN = 5;
endpackage

// >>> verilog/cwo_socket_if.sv
// Register port bundle between the bank and one socket copy.
// Assumes a single clock domain.
`timescale 1ns/10ps
interface cwo_socket_if;
   logic wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport bank (output wr, output addr, output wdata, input rdata);
   modport sock (input wr, input addr, input wdata, output rdata);
endinterface

// >>> verilog/cwo_bank.sv
// Top of the dual-socket card window offset register bank.
// Assumes a byte-wide host port synchronous to clk_i; reads land one
// cycle after the address is presented.
`timescale 1ns/10ps
module cwo_bank
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Host register port
   input wire logic reg_wr_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Host memory window access
   input wire logic mem_req_i,
   input wire logic mem_write_i,
   input wire logic mem_sock_b_i,
   input wire logic [2:0] mem_win_i,
   input wire logic [19:0] mem_addr_i,
   output logic mem_done_o,
   output logic card_cycle_o,
   output logic card_write_o,
   output logic card_attr_o,
   output logic [25:0] card_addr_o,
   // Card events, one set per socket
   input wire logic [1:0] card_removed_i,
   input wire logic [1:0] detect_change_i,
   input wire logic [1:0] status_clear_i,
   input wire logic [1:0] detect_int_enable_i,
   input wire logic [1:0] voltage_sense_one_i,
   input wire logic [1:0] voltage_sense_two_i,
   // Socket outputs
   output logic [15:0] io_off0_a_o,
   output logic [15:0] io_off1_a_o,
   output logic [15:0] io_off0_b_o,
   output logic [15:0] io_off1_b_o,
   output logic [1:0] soft_detect_interrupt_o,
   output logic [1:0] ring_indicate_output_o
);
   cwo_socket_if sa ();
   cwo_socket_if sb ();
   logic [7:0] mem_hi_a [5];
   logic [7:0] mem_hi_b [5];
   logic [7:0] local_off;
   logic hit_b;
   logic sel_b_reg;
   logic [7:0] win_byte;
   logic done_reg;
   logic cyc_reg;
   logic wr_reg;
   logic attr_reg;
   logic [25:0] addr_reg;

   // Alias at base+800h maps onto the same local offsets
   function automatic logic [7:0] local_of(input logic [11:0] a);
      logic [11:0] d;
      d = (a >= cwo_pkg::CWO_ALIAS_BASE) ? a - cwo_pkg::CWO_ALIAS_BASE : a;
      return d[7:0];
   endfunction

   assign local_off = local_of(reg_addr_i);
   assign hit_b = local_off >= cwo_pkg::CWO_SOCKET_B_DELTA;

   assign sa.wr = reg_wr_i & ~hit_b;
   assign sa.addr = local_off;
   assign sa.wdata = reg_wdata_i;
   assign sb.wr = reg_wr_i & hit_b;
   assign sb.addr = local_off - cwo_pkg::CWO_SOCKET_B_DELTA;
   assign sb.wdata = reg_wdata_i;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         sel_b_reg <= 1'b0;
      else
         sel_b_reg <= hit_b;
   end

   assign reg_rdata_o = sel_b_reg ? sb.rdata : sa.rdata;

   cwo_socket u_sock_a (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .rp(sa.sock),
      .card_removed_i(card_removed_i[0]),
      .detect_change_i(detect_change_i[0]),
      .status_clear_i(status_clear_i[0]),
      .detect_int_enable_i(detect_int_enable_i[0]),
      .voltage_sense_one_i(voltage_sense_one_i[0]),
      .voltage_sense_two_i(voltage_sense_two_i[0]),
      .mem_hi_o(mem_hi_a),
      .io_off0_o(io_off0_a_o),
      .io_off1_o(io_off1_a_o),
      .soft_detect_interrupt_o(soft_detect_interrupt_o[0]),
      .ring_indicate_output_o(ring_indicate_output_o[0])
   );

   cwo_socket u_sock_b (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .rp(sb.sock),
      .card_removed_i(card_removed_i[1]),
      .detect_change_i(detect_change_i[1]),
      .status_clear_i(status_clear_i[1]),
      .detect_int_enable_i(detect_int_enable_i[1]),
      .voltage_sense_one_i(voltage_sense_one_i[1]),
      .voltage_sense_two_i(voltage_sense_two_i[1]),
      .mem_hi_o(mem_hi_b),
      .io_off0_o(io_off0_b_o),
      .io_off1_o(io_off1_b_o),
      .soft_detect_interrupt_o(soft_detect_interrupt_o[1]),
      .ring_indicate_output_o(ring_indicate_output_o[1])
   );

   // Out-of-range window numbers fall back to window 0
   always_comb
   begin
      win_byte = mem_sock_b_i ? mem_hi_b[0] : mem_hi_a[0];
      for (int i = 1; i < cwo_pkg::CWO_NUM_MEMWIN; i++)
         if (mem_win_i == 3'(i))
            win_byte = mem_sock_b_i ? mem_hi_b[i] : mem_hi_a[i];
   end

   // Protected writes still complete on the host side
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         done_reg <= 1'b0;
         cyc_reg <= 1'b0;
         wr_reg <= 1'b0;
         attr_reg <= 1'b0;
         addr_reg <= 26'h0000000;
      end
      else
      begin
         done_reg <= mem_req_i;
         cyc_reg <= mem_req_i &
            ~(mem_write_i & win_byte[cwo_pkg::CWO_WP_BIT]);
         wr_reg <= mem_req_i & mem_write_i;
         attr_reg <= win_byte[cwo_pkg::CWO_ATTR_BIT];
         addr_reg <= {win_byte[5:0], mem_addr_i};
      end
   end

   assign mem_done_o = done_reg;
   assign card_cycle_o = cyc_reg;
   assign card_write_o = wr_reg;
   assign card_attr_o = attr_reg;
   assign card_addr_o = addr_reg;
endmodule // cwo_bank

// >>> tb/cwo_bank_sva.sv
// Port checker for the card window offset register bank.
// Bound to cwo_bank from the bench top file; one clock domain.
`timescale 1ns/10ps
module cwo_bank_sva
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Watched ports
   input wire logic reg_wr_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic mem_req_i,
   input wire logic mem_write_i,
   input wire logic [19:0] mem_addr_i,
   input wire logic mem_done_o,
   input wire logic card_cycle_o,
   input wire logic card_write_o,
   input wire logic [25:0] card_addr_o,
   input wire logic [1:0] detect_change_i,
   input wire logic [1:0] status_clear_i,
   input wire logic [1:0] detect_int_enable_i,
   input wire logic [1:0] voltage_sense_one_i,
   input wire logic [1:0] voltage_sense_two_i,
   input wire logic [15:0] io_off0_a_o,
   input wire logic [1:0] soft_detect_interrupt_o,
   input wire logic [1:0] ring_indicate_output_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   done_after_req_a: assert property (
      mem_req_i |=> mem_done_o) else $error("no done after request");
   cycle_has_cause_a: assert property (
      card_cycle_o |-> mem_done_o && $past(mem_req_i))
      else $error("card cycle without request");
   card_addr_low_a: assert property (
      card_cycle_o |-> card_addr_o[19:0] == $past(mem_addr_i)
      && card_write_o == $past(mem_write_i)) else $error("card cycle bad");
   io_low_even_a: assert property (
      reg_wr_i && reg_addr_i == 12'h036 |=>
      io_off0_a_o[7:0] == ($past(reg_wdata_i) & 8'hFE))
      else $error("io low byte wrong");
   io_high_write_a: assert property (
      reg_wr_i && reg_addr_i == 12'h037 |=>
      io_off0_a_o[15:8] == $past(reg_wdata_i)) else $error("io high wrong");
   detect_zero_bits_a: assert property (
      $past(reg_addr_i) == 12'h016 |-> (reg_rdata_o & 8'h2D) == 8'h00)
      else $error("detect reserved bits set");
   sense_live_a: assert property (
      $past(reg_addr_i) == 12'h016 && $stable(voltage_sense_one_i)
      && $stable(voltage_sense_two_i) |-> reg_rdata_o[7:6] ==
      {voltage_sense_two_i[0], voltage_sense_one_i[0]})
      else $error("sense bits not live");
   soft_int_cause_a: assert property (
      soft_detect_interrupt_o[0] |-> $past(reg_wr_i && reg_wdata_i[5]
      && (reg_addr_i == 12'h016 || reg_addr_i == 12'h816)
      && detect_int_enable_i[0]))
      else $error("soft interrupt without cause");
   ring_fall_cause_a: assert property (
      $fell(ring_indicate_output_o[0]) |-> $past(detect_change_i[0]))
      else $error("ring fell without change");
   ring_held_low_a: assert property (
      !ring_indicate_output_o[0] && !status_clear_i[0] |=>
      !ring_indicate_output_o[0]) else $error("ring released early");
endmodule // cwo_bank_sva

// >>> tb/cwo_bank_tb.sv
// Self-checking bench for the card window offset register bank.
// Drives all inputs at the falling edge; needs cwo_pkg and the checker.
`timescale 1ns/10ps
module cwo_bank_tb;
   logic clk_i, rst_n_i, reg_wr_i, mem_req_i, mem_write_i, mem_sock_b_i;
   logic [11:0] reg_addr_i;
   logic [7:0] reg_wdata_i, reg_rdata_o;
   logic [2:0] mem_win_i;
   logic [19:0] mem_addr_i;
   logic mem_done_o, card_cycle_o, card_write_o, card_attr_o;
   logic [25:0] card_addr_o;
   logic [1:0] card_removed_i, detect_change_i, status_clear_i;
   logic [1:0] detect_int_enable_i, voltage_sense_one_i;
   logic [1:0] voltage_sense_two_i, soft_detect_interrupt_o;
   logic [1:0] ring_indicate_output_o;
   logic [15:0] io_off0_a_o, io_off1_a_o, io_off0_b_o, io_off1_b_o;
   localparam logic [7:0] HI [5] = '{8'h41, 8'h02, 8'h7F, 8'h20, 8'h55};
   int n_mismatch = 0;
   int total_checks = 0;
   int cycles = 0;
   cwo_bank i_cwo_bank (.*);
   task automatic check(input string what, input logic [29:0] seen,
      input logic [29:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk_i);
      reg_wr_i = 1'h1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge clk_i);
      reg_wr_i = 1'h0;
   endtask
   // Read data is registered, so it is judged one cycle after the address
   task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
      @(negedge clk_i);
      reg_addr_i = a;
      @(negedge clk_i);
      check("rdata", reg_rdata_o, exp);
   endtask
   task automatic mem(input logic b, input logic [2:0] w, input logic wt,
      output logic [29:0] r);
      @(negedge clk_i);
      mem_req_i = 1'h1;
      mem_sock_b_i = b;
      mem_win_i = w;
      mem_write_i = wt;
      @(negedge clk_i);
      mem_req_i = 1'h0;
      r = {mem_done_o, card_cycle_o, card_write_o, card_attr_o, card_addr_o};
   endtask
   task automatic t_reset;
      for (int i = 0; i < 5; i++)
      begin
         rdc({4'h0, cwo_pkg::CWO_MEMHI_A[i]}, 8'h00);
         rdc(12'h036 + i[11:0], 8'h00);
         rdc(12'h076 + i[11:0], 8'h00);
      end
      rdc(12'h016, 8'h40);
      rdc(12'h056, 8'h80);
   endtask
   task automatic t_io;
      wr(12'h036, 8'hFF);
      wr(12'h037, 8'hA5);
      wr(12'h838, 8'h3C);
      wr(12'h039, 8'h81);
      wr(12'h076, 8'h5B);
      wr(12'h877, 8'hC6);
      check("io0a", io_off0_a_o, 16'hA5FE);
      check("io1a", io_off1_a_o, 16'h813C);
      check("io0b", io_off0_b_o, 16'hC65A);
      check("io1b", io_off1_b_o, 16'h0000);
      rdc(12'h836, 8'hFE);
      rdc(12'h03F, 8'h00);
   endtask
   task automatic t_mem;
      logic [29:0] r;
      for (int i = 0; i < 5; i++)
      begin
         wr({4'h0, cwo_pkg::CWO_MEMHI_A[i]}, HI[i]);
         mem(1'h0, i[2:0], 1'h0, r);
         check("win", r, {3'h6, HI[i][6], HI[i][5:0], 20'hA5C3F});
      end
      wr(12'h015, 8'hC1);
      mem(1'h0, 3'h0, 1'h1, r);
      check("wp", r[29:28], 2'h2);
      mem(1'h0, 3'h0, 1'h0, r);
      check("wprd", r[29:28], 2'h3);
      wr(12'h015, 8'h01);
      mem(1'h0, 3'h0, 1'h1, r);
      check("wr", r, {4'hE, 6'h01, 20'hA5C3F});
      wr(12'h055, 8'h4A);
      mem(1'h1, 3'h0, 1'h0, r);
      check("winb", r, {4'hD, 6'h0A, 20'hA5C3F});
   endtask
   task automatic t_det;
      wr(12'h016, 8'hFF);
      check("nosoft", soft_detect_interrupt_o, 2'h0);
      rdc(12'h016, 8'h52);
      detect_int_enable_i = 2'h1;
      wr(12'h016, 8'h32);
      check("soft", soft_detect_interrupt_o, 2'h1);
      @(negedge clk_i);
      check("soft1", soft_detect_interrupt_o, 2'h0);
      detect_change_i = 2'h3;
      @(negedge clk_i);
      detect_change_i = 2'h0;
      repeat (3) @(negedge clk_i);
      check("ring", ring_indicate_output_o, 2'h2);
      status_clear_i = 2'h1;
      @(negedge clk_i);
      status_clear_i = 2'h0;
      check("ringclr", ring_indicate_output_o, 2'h3);
      // Only socket A asked to be cleared on removal
      card_removed_i = 2'h3;
      @(negedge clk_i);
      card_removed_i = 2'h0;
      check("rem_a", io_off0_a_o, 16'h0000);
      check("rem_b", io_off0_b_o, 16'hC65A);
      rdc(12'h015, 8'h00);
      rdc(12'h016, 8'h40);
      // Socket B through the alias: soft pulse, then cleared on removal
      detect_int_enable_i = 2'h3;
      wr(12'h856, 8'h22);
      check("soft_b", soft_detect_interrupt_o, 2'h2);
      card_removed_i = 2'h2;
      @(negedge clk_i);
      card_removed_i = 2'h0;
      check("rem_b2", io_off0_b_o, 16'h0000);
      voltage_sense_one_i = 2'h2;
      voltage_sense_two_i = 2'h0;
      rdc(12'h856, 8'h40);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      clk_i = 1'h0;
      forever #10 clk_i = ~clk_i;
   end
   // Cuts a hang short well past the hundred or so cycles the tests need
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         test_done;
      end
   end
   initial
   begin
      {rst_n_i, reg_wr_i, mem_req_i, mem_write_i, mem_sock_b_i} = 5'h0;
      {reg_addr_i, reg_wdata_i, mem_win_i} = 23'h0;
      mem_addr_i = 20'hA5C3F;
      {card_removed_i, detect_change_i, status_clear_i} = 6'h0;
      detect_int_enable_i = 2'h0;
      voltage_sense_one_i = 2'h1;
      voltage_sense_two_i = 2'h2;
      repeat (8) @(negedge clk_i);
      rst_n_i = 1'h1;
      t_reset;
      t_io;
      t_mem;
      t_det;
      test_done;
   end
endmodule // cwo_bank_tb
bind cwo_bank cwo_bank_sva i_cwo_bank_sva (.*);
